/* include/monitor_cfg_pkg.sv */
// constants for the temperature-encoding and pin-function configuration registers
package monitor_cfg_pkg;
  // register offsets on the internal register port
  localparam logic [7:0] ENC_REG_ADDR = 8'h7C;
  localparam logic [7:0] PIN_REG_ADDR = 8'h7D;
  // power-on values and unmapped read value
  localparam logic [7:0] ENC_REG_RESET = 8'h05;
  localparam logic [7:0] PIN_REG_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // encoding and overtemp enable register fields
  localparam int TWOS_COMPLEMENT_SELECT_BIT = 0;
  localparam int OFFSET_RANGE_SELECT_BIT = 1;
  localparam int FIRST_MULTIPIN_FUNCTION_LSB = 2;
  localparam int CPU_LINK_OVERTEMP_ENABLE_BIT = 4;
  localparam int REMOTE_ONE_OVERTEMP_ENABLE_BIT = 5;
  localparam int LOCAL_OVERTEMP_ENABLE_BIT = 6;
  localparam int REMOTE_TWO_OVERTEMP_ENABLE_BIT = 7;
  // pin function and attenuator bypass register fields
  localparam int SECOND_MULTIPIN_FUNCTION_LSB = 0;
  localparam int OVERTEMP_GLOBAL_DISABLE_BIT = 2;
  localparam int DIVIDER_BYPASS_LSB = 3;
  localparam int DIVIDER_BYPASS_WIDTH = 5;
  // first multipurpose pin function codes
  localparam logic [1:0] FIRST_FN_ALERT = 2'h0;
  localparam logic [1:0] FIRST_FN_OVERTEMP = 2'h1;
  localparam logic [1:0] FIRST_FN_GPIO_THREE = 2'h2;
  // second multipurpose pin function codes
  localparam logic [1:0] SECOND_FN_FAN_FOUR = 2'h0;
  localparam logic [1:0] SECOND_FN_OVERTEMP = 2'h1;
  localparam logic [1:0] SECOND_FN_ALERT = 2'h2;
  localparam logic [1:0] FN_RESERVED = 2'h3;
  // temperature encodings
  localparam logic [8:0] OFFSET64_BIAS = 9'h040;
  localparam logic [7:0] MIN_CODE_OFFSET64 = 8'h00;
  localparam logic [7:0] MIN_CODE_TWOS = 8'h80;
endpackage

/* rtl/monitor_config_regs_four_five.sv */
// temperature-encoding / overtemp enable and pin-function / attenuator bypass registers

// Notes on behaviour
// - writes to both registers are ignored while the global lock bit is one
// - bit 0 picks twos complement or offset-64; the three sensor comparisons follow it at once
// - bit 1 picks half-degree or one-degree step for the three sensor offsets
// - the processor-interface offset always uses one-degree steps
// - bits 3:2 pick first pin: alert, overtemp, general pin three, reserved
// - bit 4 lets the processor-interface channel drive the overtemp pin
// - bit 5 lets remote sensor one drive the overtemp pin
// - bit 6 lets the on-chip sensor drive the overtemp pin
// - bit 7 lets remote sensor two drive the overtemp pin
// - a channel whose limit holds the minimum code never drives overtemp
// - processor-interface channel never drives when its limit is -128 degrees
// - bits 1:0 of second register pick fan-four input, overtemp, alert, reserved
// - bit 2 of second register disables overtemp output on every channel
// - bits 3 to 7 bypass the five voltage input dividers
// - power-on values are 0x05 and 0x00
module monitor_config_regs_four_five (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // register port from the serial management slave
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wr_data,
  output logic [7:0] o_rd_data,
  input wire logic i_lock,
  // temperature readings and limits, raw register codes
  input wire logic [7:0] i_local_temp,
  input wire logic [7:0] i_remote_one_temp,
  input wire logic [7:0] i_remote_two_temp,
  input wire logic [7:0] i_cpu_temp,
  input wire logic [7:0] i_local_limit,
  input wire logic [7:0] i_remote_one_limit,
  input wire logic [7:0] i_remote_two_limit,
  input wire logic [7:0] i_cpu_limit,
  // raw offset codes
  input wire logic [7:0] i_remote_one_offset,
  input wire logic [7:0] i_local_offset,
  input wire logic [7:0] i_remote_two_offset,
  input wire logic [7:0] i_cpu_offset,
  // signals that may be routed to the pins
  input wire logic i_alert_req,
  input wire logic i_gpio_three_out,
  input wire logic i_gpio_three_oe,
  // first multipurpose pin
  input wire logic i_first_multipin_in,
  output logic o_first_multipin_out,
  output logic o_first_multipin_oe,
  // second multipurpose pin
  input wire logic i_second_multipin_in,
  output logic o_second_multipin_out,
  output logic o_second_multipin_oe,
  // pin values returned to the core
  output logic o_overtemp_pin_in_n,
  output logic o_fan_four_speed_input,
  output logic o_general_purpose_pin_three_in,
  output logic o_overtemp_active,
  // configuration seen by the measurement core
  output logic o_twos_complement_select,
  output logic [4:0] o_divider_bypass,
  output logic signed [8:0] o_remote_one_offset_half,
  output logic signed [8:0] o_local_offset_half,
  output logic signed [8:0] o_remote_two_offset_half,
  output logic signed [8:0] o_cpu_offset_half
);

  typedef struct packed {
    logic [7:0] enc_reg;
    logic [7:0] pin_reg;
    logic [1:0] first_fn;
    logic [1:0] second_fn;
    logic [1:0] first_sync;
    logic [1:0] second_sync;
    logic [7:0] rd_data;
    logic first_out;
    logic first_oe;
    logic second_out;
    logic second_oe;
    logic overtemp_in_n;
    logic fan_four_in;
    logic gpio_three_in;
    logic overtemp_active;
    logic signed [8:0] r1_off;
    logic signed [8:0] loc_off;
    logic signed [8:0] r2_off;
    logic signed [8:0] cpu_off;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // code to degrees under the selected encoding
  function automatic logic signed [8:0] to_degrees(input logic [7:0] code, input logic twos);
    logic signed [8:0] val;
    val = twos ? 9'(signed'(code)) : signed'({1'b0, code} - monitor_cfg_pkg::OFFSET64_BIAS);
    return val;
  endfunction

  function automatic logic is_min_code(input logic [7:0] code, input logic twos);
    return twos ? (code == monitor_cfg_pkg::MIN_CODE_TWOS)
                : (code == monitor_cfg_pkg::MIN_CODE_OFFSET64);
  endfunction

  // offset code to half-degree units; full step doubles the code
  function automatic logic signed [8:0] to_half_deg(input logic [7:0] code, input logic full);
    logic signed [8:0] val;
    val = 9'(signed'(code));
    return full ? signed'({val[7:0], 1'b0}) : val;
  endfunction

  function automatic logic channel_hot(input logic [7:0] temp, input logic [7:0] limit,
                                       input logic twos, input logic en);
    return en && !is_min_code(limit, twos) && (to_degrees(temp, twos) > to_degrees(limit, twos));
  endfunction

  logic twos;
  logic full_step;
  logic enc_wr;
  logic pin_wr;
  logic first_is_ot;
  logic second_is_ot;
  logic cpu_hot;
  logic r1_hot;
  logic loc_hot;
  logic r2_hot;
  logic ot_drive;

  always_comb begin
    st_nxt = st_r;
    twos = st_r.enc_reg[monitor_cfg_pkg::TWOS_COMPLEMENT_SELECT_BIT];
    full_step = st_r.enc_reg[monitor_cfg_pkg::OFFSET_RANGE_SELECT_BIT];
    enc_wr = i_wr_en && !i_lock && (i_addr == monitor_cfg_pkg::ENC_REG_ADDR);
    pin_wr = i_wr_en && !i_lock && (i_addr == monitor_cfg_pkg::PIN_REG_ADDR);

    if (enc_wr) begin
      st_nxt.enc_reg = i_wr_data;
      // reserved code is kept in the register but the pin stays as it was
      if (i_wr_data[monitor_cfg_pkg::FIRST_MULTIPIN_FUNCTION_LSB +: 2] !=
          monitor_cfg_pkg::FN_RESERVED) begin
        st_nxt.first_fn = i_wr_data[monitor_cfg_pkg::FIRST_MULTIPIN_FUNCTION_LSB +: 2];
      end
    end
    if (pin_wr) begin
      st_nxt.pin_reg = i_wr_data;
      if (i_wr_data[monitor_cfg_pkg::SECOND_MULTIPIN_FUNCTION_LSB +: 2] !=
          monitor_cfg_pkg::FN_RESERVED) begin
        st_nxt.second_fn =
          i_wr_data[monitor_cfg_pkg::SECOND_MULTIPIN_FUNCTION_LSB +: 2];
      end
    end

    // read data is registered; unmapped offsets read zero
    if (i_rd_en) begin
      if (i_addr == monitor_cfg_pkg::ENC_REG_ADDR) begin
        st_nxt.rd_data = st_r.enc_reg;
      end else if (i_addr == monitor_cfg_pkg::PIN_REG_ADDR) begin
        st_nxt.rd_data = st_r.pin_reg;
      end else begin
        st_nxt.rd_data = monitor_cfg_pkg::UNMAPPED_READ;
      end
    end

    // pins come from outside the clock domain
    st_nxt.first_sync = {st_r.first_sync[0], i_first_multipin_in};
    st_nxt.second_sync = {st_r.second_sync[0], i_second_multipin_in};

    first_is_ot = (st_r.first_fn == monitor_cfg_pkg::FIRST_FN_OVERTEMP);
    second_is_ot = (st_r.second_fn == monitor_cfg_pkg::SECOND_FN_OVERTEMP);

    // processor-interface temperatures are always signed; -128 limit suppresses it
    cpu_hot = st_r.enc_reg[monitor_cfg_pkg::CPU_LINK_OVERTEMP_ENABLE_BIT] &&
              (i_cpu_limit != monitor_cfg_pkg::MIN_CODE_TWOS) &&
              (signed'(i_cpu_temp) > signed'(i_cpu_limit));
    r1_hot = channel_hot(i_remote_one_temp, i_remote_one_limit, twos,
                         st_r.enc_reg[monitor_cfg_pkg::REMOTE_ONE_OVERTEMP_ENABLE_BIT]);
    loc_hot = channel_hot(i_local_temp, i_local_limit, twos,
                          st_r.enc_reg[monitor_cfg_pkg::LOCAL_OVERTEMP_ENABLE_BIT]);
    r2_hot = channel_hot(i_remote_two_temp, i_remote_two_limit, twos,
                         st_r.enc_reg[monitor_cfg_pkg::REMOTE_TWO_OVERTEMP_ENABLE_BIT]);
    ot_drive = !st_r.pin_reg[monitor_cfg_pkg::OVERTEMP_GLOBAL_DISABLE_BIT] &&
               (cpu_hot || r1_hot || loc_hot || r2_hot);
    // the timer limit outside this block must sit at all ones while we drive
    st_nxt.overtemp_active = ot_drive && (first_is_ot || second_is_ot);

    // alert and overtemp functions pull low while asserted, release otherwise; general pin three drives i_gpio_three_out under i_gpio_three_oe
    unique case (st_r.first_fn)
      monitor_cfg_pkg::FIRST_FN_ALERT: begin
        st_nxt.first_out = 1'b0;
        st_nxt.first_oe = i_alert_req;
      end
      monitor_cfg_pkg::FIRST_FN_OVERTEMP: begin
        st_nxt.first_out = 1'b0;
        st_nxt.first_oe = ot_drive;
      end
      monitor_cfg_pkg::FIRST_FN_GPIO_THREE: begin
        st_nxt.first_out = i_gpio_three_out;
        st_nxt.first_oe = i_gpio_three_oe;
      end
      default: begin
        st_nxt.first_out = 1'b0;
        st_nxt.first_oe = 1'b0;
      end
    endcase
    unique case (st_r.second_fn)
      monitor_cfg_pkg::SECOND_FN_FAN_FOUR: begin
        st_nxt.second_out = 1'b0;
        st_nxt.second_oe = 1'b0;
      end
      monitor_cfg_pkg::SECOND_FN_OVERTEMP: begin
        st_nxt.second_out = 1'b0;
        st_nxt.second_oe = ot_drive;
      end
      monitor_cfg_pkg::SECOND_FN_ALERT: begin
        st_nxt.second_out = 1'b0;
        st_nxt.second_oe = i_alert_req;
      end
      default: begin
        st_nxt.second_out = 1'b0;
        st_nxt.second_oe = 1'b0;
      end
    endcase

    // timer input sees either pin configured for overtemp; idle high
    st_nxt.overtemp_in_n = (!first_is_ot || st_r.first_sync[1]) &&
                           (!second_is_ot || st_r.second_sync[1]);
    st_nxt.fan_four_in = (st_r.second_fn == monitor_cfg_pkg::SECOND_FN_FAN_FOUR) &&
                         st_r.second_sync[1];
    st_nxt.gpio_three_in = (st_r.first_fn == monitor_cfg_pkg::FIRST_FN_GPIO_THREE) &&
                           st_r.first_sync[1];

    st_nxt.r1_off = to_half_deg(i_remote_one_offset, full_step);
    st_nxt.loc_off = to_half_deg(i_local_offset, full_step);
    st_nxt.r2_off = to_half_deg(i_remote_two_offset, full_step);
    st_nxt.cpu_off = to_half_deg(i_cpu_offset, 1'b1);
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      st_r <= '0;
      st_r.enc_reg <= monitor_cfg_pkg::ENC_REG_RESET;
      st_r.pin_reg <= monitor_cfg_pkg::PIN_REG_RESET;
      st_r.first_fn <=
        monitor_cfg_pkg::ENC_REG_RESET[monitor_cfg_pkg::FIRST_MULTIPIN_FUNCTION_LSB +: 2];
      st_r.second_fn <=
        monitor_cfg_pkg::PIN_REG_RESET[monitor_cfg_pkg::SECOND_MULTIPIN_FUNCTION_LSB +: 2];
      st_r.first_sync <= 2'h3;
      st_r.second_sync <= 2'h3;
      st_r.overtemp_in_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_rd_data = st_r.rd_data;
  assign o_first_multipin_out = st_r.first_out;
  assign o_first_multipin_oe = st_r.first_oe;
  assign o_second_multipin_out = st_r.second_out;
  assign o_second_multipin_oe = st_r.second_oe;
  assign o_overtemp_pin_in_n = st_r.overtemp_in_n;
  assign o_fan_four_speed_input = st_r.fan_four_in;
  assign o_general_purpose_pin_three_in = st_r.gpio_three_in;
  assign o_overtemp_active = st_r.overtemp_active;
  assign o_twos_complement_select = st_r.enc_reg[monitor_cfg_pkg::TWOS_COMPLEMENT_SELECT_BIT];
  // a set bit rescales that channel to 0 V..2 V over the full code range
  assign o_divider_bypass = st_r.pin_reg[monitor_cfg_pkg::DIVIDER_BYPASS_LSB +:
                                         monitor_cfg_pkg::DIVIDER_BYPASS_WIDTH];
  assign o_remote_one_offset_half = st_r.r1_off;
  assign o_local_offset_half = st_r.loc_off;
  assign o_remote_two_offset_half = st_r.r2_off;
  assign o_cpu_offset_half = st_r.cpu_off;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  a_lock_blocks_write: assert property (
    i_lock && i_wr_en |=> $stable(st_r.enc_reg) && $stable(st_r.pin_reg))
    else $error("locked write changed a register");

  a_write_stores_data: assert property (
    !i_lock && i_wr_en && i_addr == monitor_cfg_pkg::PIN_REG_ADDR
    |=> st_r.pin_reg == $past(i_wr_data))
    else $error("unlocked write not stored");

  a_reserved_keeps_fn: assert property (
    !i_lock && i_wr_en && i_addr == monitor_cfg_pkg::ENC_REG_ADDR && i_wr_data[3:2] == 2'h3
    |=> st_r.first_fn == $past(st_r.first_fn) && st_r.enc_reg[3:2] == 2'h3)
    else $error("reserved code changed the pin function");

  a_global_disable_off: assert property (
    st_r.pin_reg[2] && st_r.first_fn == 2'h1 |=> !o_first_multipin_oe && !o_overtemp_active)
    else $error("overtemp driven while globally disabled");

  a_local_drives_pin: assert property (
    st_r.first_fn == 2'h1 && !st_r.pin_reg[2] && st_r.enc_reg[6] &&
    !is_min_code(i_local_limit, st_r.enc_reg[0]) &&
    to_degrees(i_local_temp, st_r.enc_reg[0]) > to_degrees(i_local_limit, st_r.enc_reg[0])
    |=> o_first_multipin_oe && !o_first_multipin_out)
    else $error("local overtemp not driven on first pin");

  a_min_limit_quiet: assert property (
    st_r.enc_reg[7:4] == 4'h4 && is_min_code(i_local_limit, st_r.enc_reg[0])
    |=> !o_overtemp_active)
    else $error("minimum limit did not suppress overtemp");

  a_cpu_min_quiet: assert property (
    st_r.enc_reg[7:4] == 4'h1 && i_cpu_limit == 8'h80 |=> !o_overtemp_active)
    else $error("cpu limit of -128 did not suppress overtemp");

  a_power_on_values: assert property (
    $fell(i_reset) |-> st_r.enc_reg == monitor_cfg_pkg::ENC_REG_RESET &&
    st_r.pin_reg == monitor_cfg_pkg::PIN_REG_RESET && o_rd_data == 8'h00)
    else $error("power-on value wrong");

  a_cpu_offset_full: assert property (
    ##1 o_cpu_offset_half == signed'({$past(i_cpu_offset), 1'b0}))
    else $error("cpu offset not in one-degree steps");

  a_sensor_half_step: assert property (
    !st_r.enc_reg[1] |=> o_local_offset_half == 9'(signed'($past(i_local_offset))))
    else $error("sensor offset not in half-degree steps");

  a_second_reserved_keeps: assert property (
    !i_lock && i_wr_en && i_addr == monitor_cfg_pkg::PIN_REG_ADDR && i_wr_data[1:0] == 2'h3
    |=> st_r.second_fn == $past(st_r.second_fn) && st_r.pin_reg[1:0] == 2'h3)
    else $error("reserved code changed the second pin function");

  a_cpu_link_drives: assert property (
    st_r.first_fn == 2'h1 && !st_r.pin_reg[2] && st_r.enc_reg[4] && i_cpu_limit != 8'h80 &&
    signed'(i_cpu_temp) > signed'(i_cpu_limit)
    |=> o_first_multipin_oe && o_overtemp_active)
    else $error("processor-interface overtemp not driven");

  c_locked_write: cover property (i_lock && i_wr_en && i_addr == monitor_cfg_pkg::ENC_REG_ADDR);
  c_second_pin_ot: cover property (st_r.second_fn == 2'h1 ##1 o_second_multipin_oe);
  c_reserved_write: cover property (!i_lock && i_wr_en && i_wr_data[1:0] == 2'h3 &&
                                    i_addr == monitor_cfg_pkg::PIN_REG_ADDR);
  c_encoding_flip: cover property ($changed(st_r.enc_reg[0]) ##1 o_overtemp_active);

endmodule

/* test/monitor_config_regs_four_five_tb.sv */
// self-checking testbench for the encoding / pin-function configuration registers
module monitor_config_regs_four_five_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, lock = 1'b0, alert = 1'b0;
  logic g3o = 1'b0, g3e = 1'b0, p1 = 1'b1, p2 = 1'b1;
  logic [7:0] addr = 8'h00, wd = 8'h00, lt = 8'h00, r1t = 8'h00, r2t = 8'h00, ct = 8'h00;
  logic [7:0] ll = 8'h7F, r1l = 8'h7F, r2l = 8'h7F, cl = 8'h7F;
  logic [7:0] r1o = 8'h00, lo = 8'h00, r2o = 8'h00, co = 8'h00, rdd;
  logic p1o, p1e, p2o, p2e, ot_in_n, fan4, g3in, ot_act, twos;
  logic [4:0] byp;
  logic signed [8:0] r1h, lh, r2h, ch;
  int mismatches = 0;
  int n_checks = 0;

  always #25 clk = ~clk;

  monitor_config_regs_four_five u_monitor_config_regs_four_five (
    .i_ref_clk(clk), .i_reset(rst), .i_wr_en(wr), .i_rd_en(rd), .i_addr(addr),
    .i_wr_data(wd), .o_rd_data(rdd), .i_lock(lock),
    .i_local_temp(lt), .i_remote_one_temp(r1t), .i_remote_two_temp(r2t), .i_cpu_temp(ct),
    .i_local_limit(ll), .i_remote_one_limit(r1l), .i_remote_two_limit(r2l), .i_cpu_limit(cl),
    .i_remote_one_offset(r1o), .i_local_offset(lo), .i_remote_two_offset(r2o),
    .i_cpu_offset(co), .i_alert_req(alert), .i_gpio_three_out(g3o), .i_gpio_three_oe(g3e),
    .i_first_multipin_in(p1), .o_first_multipin_out(p1o), .o_first_multipin_oe(p1e),
    .i_second_multipin_in(p2), .o_second_multipin_out(p2o), .o_second_multipin_oe(p2e),
    .o_overtemp_pin_in_n(ot_in_n), .o_fan_four_speed_input(fan4),
    .o_general_purpose_pin_three_in(g3in), .o_overtemp_active(ot_act),
    .o_twos_complement_select(twos), .o_divider_bypass(byp),
    .o_remote_one_offset_half(r1h), .o_local_offset_half(lh),
    .o_remote_two_offset_half(r2h), .o_cpu_offset_half(ch)
  );

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wd = d;
    @(negedge clk);
    wr = 1'b0;
  endtask

  task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    rd = 1'b0;
    chk(what, {1'b0, exp}, {1'b0, rdd});
  endtask

  // pins settle within two cycles; four leaves margin for the synchronisers
  task automatic pin_chk(input string what, input logic exp_oe);
    repeat (4) @(negedge clk);
    chk(what, {6'h00, exp_oe, exp_oe, 1'b0}, {6'h00, p1e, ot_act, p1o});
  endtask

  // channel index follows its enable bit: 4 cpu, 5 remote one, 6 local, 7 remote two
  task automatic set_ch(input int i, input logic [7:0] t, input logic [7:0] l);
    @(negedge clk);
    case (i)
      4: begin ct = t; cl = l; end
      5: begin r1t = t; r1l = l; end
      6: begin lt = t; ll = l; end
      default: begin r2t = t; r2l = l; end
    endcase
  endtask

  task automatic t_reset();
    rchk("enc reset", 8'h7C, 8'h05);
    rchk("pin reset", 8'h7D, 8'h00);
    rchk("unmapped", 8'h40, 8'h00);
    chk("twos out", 9'h001, {8'h00, twos});
  endtask

  task automatic t_channels();
    for (int i = 4; i < 8; i++) begin
      set_ch(i, 8'h20, 8'h10);
      wreg(8'h7C, 8'h05 | (8'h01 << i));
      pin_chk("chan on", 1'b1);
      wreg(8'h7C, 8'h05);
      pin_chk("chan off", 1'b0);
      wreg(8'h7C, 8'h05 | (8'h01 << i));
      set_ch(i, 8'h20, 8'h80);
      pin_chk("min limit", 1'b0);
      set_ch(i, 8'h00, 8'h7F);
    end
    set_ch(6, 8'h20, 8'h10);
    wreg(8'h7C, 8'h45);
    wreg(8'h7D, 8'h04);
    pin_chk("global off", 1'b0);
    wreg(8'h7D, 8'h00);
    pin_chk("global on", 1'b1);
  endtask

  // 0x90 is below 0x70 read as signed, above it read with the 64 bias
  task automatic t_encoding();
    set_ch(6, 8'h90, 8'h70);
    pin_chk("twos cmp", 1'b0);
    wreg(8'h7C, 8'h44);
    pin_chk("off64 cmp", 1'b1);
    chk("twos out", 9'h000, {8'h00, twos});
    set_ch(6, 8'h90, 8'h00);
    pin_chk("off64 min", 1'b0);
    set_ch(6, 8'h90, 8'h70);
    wreg(8'h7C, 8'h4C);
    rchk("reserved kept", 8'h7C, 8'h4C);
    pin_chk("reserved fn", 1'b1);
  endtask

  task automatic t_pins();
    // host keeps the overtemp timer limit at all ones while this pin drives
    wreg(8'h7D, 8'h01);
    repeat (4) @(negedge clk);
    chk("second ot", 9'h002, {7'h00, p2e, p2o});
    wreg(8'h7D, 8'h03);
    repeat (4) @(negedge clk);
    chk("second reserved", 9'h002, {7'h00, p2e, p2o});
    rchk("pin reserved", 8'h7D, 8'h03);
    set_ch(6, 8'h00, 8'h7F);
    @(negedge clk);
    p2 = 1'b0;
    repeat (5) @(negedge clk);
    chk("ot sense", 9'h000, {8'h00, ot_in_n});
    wreg(8'h7D, 8'h02);
    alert = 1'b1;
    repeat (4) @(negedge clk);
    chk("second alert", 9'h002, {7'h00, p2e, p2o});
    wreg(8'h7D, 8'h00);
    repeat (5) @(negedge clk);
    chk("fan low", 9'h000, {8'h00, fan4});
    p2 = 1'b1;
    repeat (5) @(negedge clk);
    chk("fan high", 9'h002, {7'h00, fan4, p2e});
    wreg(8'h7C, 8'h40);
    repeat (4) @(negedge clk);
    chk("first alert", 9'h002, {7'h00, p1e, p1o});
    alert = 1'b0;
    wreg(8'h7C, 8'h48);
    g3e = 1'b1;
    g3o = 1'b1;
    repeat (5) @(negedge clk);
    chk("first gpio", 9'h007, {6'h00, p1e, p1o, g3in});
  endtask

  task automatic t_offsets();
    @(negedge clk);
    lo = 8'hFE;
    r1o = 8'h05;
    r2o = 8'h7F;
    co = 8'h05;
    wreg(8'h7C, 8'h00);
    repeat (2) @(negedge clk);
    chk("half lcl", 9'h1FE, lh);
    chk("half r1", 9'h005, r1h);
    chk("half r2", 9'h07F, r2h);
    chk("cpu fine", 9'h00A, ch);
    wreg(8'h7C, 8'h02);
    repeat (2) @(negedge clk);
    chk("full lcl", 9'h1FC, lh);
    chk("full r2", 9'h0FE, r2h);
    chk("cpu full", 9'h00A, ch);
    wreg(8'h7D, 8'hA8);
    @(negedge clk);
    chk("bypass", 9'h015, {4'h0, byp});
    lock = 1'b1;
    wreg(8'h7D, 8'h50);
    wreg(8'h7C, 8'h11);
    rchk("locked pin", 8'h7D, 8'hA8);
    rchk("locked enc", 8'h7C, 8'h02);
    lock = 1'b0;
    wreg(8'h7D, 8'h50);
    rchk("unlocked", 8'h7D, 8'h50);
  endtask

  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_channels();
    t_encoding();
    t_pins();
    t_offsets();
    give_verdict();
  end

  // the sequence needs well under 500 cycles
  initial begin
    #200000;
    mismatches++;
    give_verdict();
  end
endmodule
